// ===== hdl/datagram_sequencer.sv
// Purpose: builds serial datagrams for a chain of stepper driver chips
// Assumes: 10 MHz core clock; serial clock derived by divider
// Notes: word memory reached over a plain address/strobe port
`timescale 1ns/1ns
`default_nettype none
`include "seq_consts.svh"
module datagram_sequencer #(
  parameter int        MOTORS      = 3,
  parameter logic [1:0] LAST_DRIVER_RESET = 2'h2
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  // word memory port
  input  wire logic [`MEM_ADDR_W-1:0]  mem_addr,
  input  wire logic [`WORD_W-1:0]      mem_wdata,
  input  wire logic                    mem_wr,
  input  wire logic                    mem_rd,
  output logic      [`WORD_W-1:0]      mem_rdata,
  // motor units
  input  wire seq_pkg::motor_ctl_t     motor_ctl [MOTORS],
  input  wire logic                    tx_request,
  input  wire logic [`DRV_W-1:0]       last_driver_index,
  // driver chain pins
  output logic                         chain_sclk,
  output logic                         chain_select_n,
  output logic                         chain_sdo,
  // status
  output logic                         busy
);
  import seq_pkg::*;

  // word memory with reset default layout
  cfg_word_t             cfg_mem [`WORD_COUNT];
  seq_state_t            state;
  motor_ctl_t            snap [MOTORS];
  logic [`DRV_W-1:0]     driver_slot_index;
  logic [`WADDR_W-1:0]   word_ptr;
  logic                  pending;
  logic [3:0]            div_cnt;
  logic                  sclk_int;
  logic                  ending;

  function automatic cfg_word_t default_word(input int idx);
    int pos;
    cfg_word_t w;
    pos = idx % 12;
    w.next_driver_flag = 1'b0;
    unique case (pos)
      0: w.code = `CODE_ONE;
      1: w.code = 5'h05;
      2: w.code = 5'h04;
      3: w.code = 5'h03;
      4: w.code = 5'h02;
      5: w.code = 5'h06;
      6: w.code = `CODE_ONE;
      7: w.code = 5'h0D;
      8: w.code = 5'h0C;
      9: w.code = 5'h0B;
      10: w.code = 5'h0A;
      default:
      begin
        w.code = 5'h0E;
        w.next_driver_flag = idx < 36;
      end
    endcase
    if (idx >= 36)
      w.code = `CODE_ZERO;
    return w;
  endfunction

  function automatic logic pick_bit(input motor_ctl_t m, input logic [4:0] code);
    logic [7:0] coil;
    logic r;
    coil = code[`COIL_B_BIT] ?
           {m.coil_b_fast_decay, m.coil_b_polarity, m.coil_b_current} :
           {m.coil_a_fast_decay, m.coil_a_polarity, m.coil_a_current};
    r = 1'b0;
    if (!code[4])
      r = coil[code[2:0]];
    else if (code == `CODE_ONE)
      r = 1'b1;
    else if (code == `CODE_DIR)
      r = m.direction;
    else if (code == `CODE_STEP)
      r = m.step;
    return r;
  endfunction

  // serial clock divider, enable pulses
  wire sclk_fall = state == ST_SHIFT && div_cnt == 4'(`SCLK_DIV - 1);
  wire sclk_rise = state == ST_SHIFT && div_cnt == 4'(`SCLK_HALF - 1);

  cfg_word_t cur_word;
  assign cur_word = cfg_mem[word_ptr];
  wire cur_bit = pick_bit(snap[driver_slot_index], cur_word.code);
  wire at_last = driver_slot_index == last_driver_index;
  wire word_done = sclk_fall;
  wire finish = word_done && cur_word.next_driver_flag && at_last;

  // bit FIFO between selector and pin shifter
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_data;
  wire  fifo_push = state == ST_SHIFT && div_cnt == 4'h0;
  seq_fifo #(
    .WIDTH (1),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (cur_bit),
    .out_valid (fifo_out_valid),
    .out_ready (sclk_fall),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < `WORD_COUNT; i++)
        cfg_mem[i] <= default_word(i);
    end
    else if (mem_wr)
      cfg_mem[mem_addr] <= cfg_word_t'(mem_wdata);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      mem_rdata <= '0;
    else if (mem_rd)
      mem_rdata <= cfg_mem[mem_addr];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      pending <= 1'b0;
    else if (tx_request && state != ST_IDLE)
      pending <= 1'b1;
    else if (state == ST_IDLE)
      pending <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state             <= ST_IDLE;
      driver_slot_index <= `DRV_FIRST;
      word_ptr          <= `WADDR_FIRST;
      div_cnt           <= '0;
      ending            <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (pending || tx_request)
            state <= ST_SNAP;
        end
        ST_SNAP:
        begin
          state             <= ST_SHIFT;
          driver_slot_index <= `DRV_FIRST;
          word_ptr          <= `WADDR_FIRST;
          div_cnt           <= '0;
        end
        ST_SHIFT:
        begin
          div_cnt <= sclk_fall ? 4'h0 : div_cnt + 4'h1;
          if (word_done)
          begin
            word_ptr <= word_ptr + 6'h01;
            if (cur_word.next_driver_flag && !at_last)
              driver_slot_index <= driver_slot_index + 2'h1;
            if (finish)
              state <= ST_END;
          end
        end
        ST_END:
        begin
          driver_slot_index <= `DRV_FIRST;
          state             <= ST_IDLE;
        end
      endcase
    end
  end

  // snapshot of control signals at datagram start
  always_ff @(posedge core_clk)
  begin
    if (state == ST_SNAP)
      snap <= motor_ctl;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      chain_sclk     <= 1'b1;
      chain_select_n <= 1'b1;
      chain_sdo      <= 1'b0;
      busy           <= 1'b0;
    end
    else
    begin
      busy           <= state != ST_IDLE;
      chain_select_n <= state != ST_SHIFT;
      if (div_cnt == 4'h1 && state == ST_SHIFT && fifo_out_valid)
        chain_sdo <= fifo_out_data;
      if (sclk_rise)
        chain_sclk <= 1'b1;
      else if (state == ST_SHIFT && div_cnt == 4'h1)
        chain_sclk <= 1'b0;
      else if (state != ST_SHIFT)
        chain_sclk <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== include/seq_consts.svh
// Purpose: constants for the driver chain datagram sequencer
// Assumes: 10 MHz core clock, words of six bits
// Notes:
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH
`define CODE_W        5
`define WORD_W        6
`define FLAG_BIT      5
`define WORD_COUNT    64
`define WADDR_W       6
`define DRV_W         2
`define CODE_ZERO     5'h10
`define CODE_ONE      5'h11
`define CODE_DIR      5'h12
`define CODE_STEP     5'h13
`define COIL_B_BIT    3
`define SCLK_DIV      10
`define SCLK_HALF     5
`define FIFO_DEPTH    8
`define DRV_FIRST     2'h0
`define WADDR_FIRST   6'h00
`define RD_NONE       6'h00
`define MEM_ADDR_W    6
`endif

// ===== include/seq_pkg.sv
// Purpose: types for the driver chain datagram sequencer
// Assumes: up to three motors
// Notes: one control bundle per motor
package seq_pkg;
  typedef struct packed
  {
    logic [5:0] coil_a_current;
    logic       coil_a_polarity;
    logic       coil_a_fast_decay;
    logic [5:0] coil_b_current;
    logic       coil_b_polarity;
    logic       coil_b_fast_decay;
    logic       direction;
    logic       step;
  } motor_ctl_t;
  typedef struct packed
  {
    logic       next_driver_flag;
    logic [4:0] code;
  } cfg_word_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SNAP, ST_SHIFT, ST_END} seq_state_t;
endpackage

// ===== hdl/seq_fifo.sv
// Purpose: small valid/ready FIFO for datagram bits
// Assumes: single clock
// Notes: depth is a power of two
`timescale 1ns/1ns
`default_nettype none
module seq_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  wire [AW:0]       fill = wr_ptr - rd_ptr;

  assign in_ready  = fill != DEPTH[AW:0];
  assign out_valid = fill != '0;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule
`default_nettype wire

// ===== dv/seq_props.sv
// Purpose: port checks for the datagram sequencer
// Assumes: one clock domain
// Notes: bound from tb_top
`timescale 1ns/1ns
`default_nettype none
`include "seq_consts.svh"
module seq_props (
  // clock and reset
  input wire logic               core_clk,
  input wire logic               rstn,
  // observed ports
  input wire logic               mem_rd,
  input wire logic [`WORD_W-1:0] mem_rdata,
  input wire logic               tx_request,
  input wire logic               chain_sclk,
  input wire logic               chain_select_n,
  input wire logic               chain_sdo,
  input wire logic               busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_IDLE: assert property (!busy |-> chain_select_n && chain_sclk)
    else $error("chain active while idle");
  AST_START: assert property (tx_request && !busy |-> ##3 !chain_select_n)
    else $error("datagram did not start");
  AST_FRAME: assert property ($fell(chain_select_n) |-> !chain_select_n [*8])
    else $error("select dropped early");
  AST_SCLK_LOW: assert property ($fell(chain_sclk) |-> !chain_sclk [*3])
    else $error("serial clock low phase short");
  AST_SDO_HOLD: assert property ($rose(chain_sclk) |-> $stable(chain_sdo))
    else $error("data moved at clock rise");
  AST_SCLK_IDLE: assert property (chain_select_n |-> chain_sclk)
    else $error("serial clock low outside frame");
  AST_RD_HOLD: assert property (!$past(mem_rd) |-> $stable(mem_rdata))
    else $error("read data changed without read");
  AST_BUSY: assert property (!chain_select_n |-> busy)
    else $error("frame without busy");
endmodule
`default_nettype wire

// ===== dv/chain_model.sv
// Purpose: behavioural driver chain
// Assumes: bits taken on rising serial clock
// Notes: each bit reported as a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
module chain_model (
  // clock
  input  wire logic core_clk,
  // chain pins
  input  wire logic chain_sclk,
  input  wire logic chain_select_n,
  input  wire logic chain_sdo,
  // received bits
  output logic      bit_valid,
  output logic      bit_val
);
  logic sclk_d = 1'b1;
  always @(posedge core_clk)
  begin
    sclk_d    <= chain_sclk;
    bit_valid <= chain_sclk && !sclk_d && !chain_select_n;
    bit_val   <= chain_sdo;
  end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Purpose: self-checking bench for the datagram sequencer
// Assumes: 10 MHz core clock
// Notes: chain bits checked against a walk of a memory mirror
`timescale 1ns/1ns
`default_nettype none
`include "seq_consts.svh"
module tb_top;
  import seq_pkg::*;
  logic       core_clk = 1'b0;
  logic       rstn = 1'b0;
  logic [5:0] mem_addr = 6'h00;
  logic [5:0] mem_wdata = 6'h00;
  logic       mem_wr = 1'b0;
  logic       mem_rd = 1'b0;
  logic       tx_request = 1'b0;
  logic [1:0] last_driver_index = 2'h2;
  logic       rd_seen = 1'b0;
  logic [5:0] mem_rdata;
  logic       chain_sclk, chain_select_n, chain_sdo, busy, bit_valid, bit_val;
  motor_ctl_t motor_ctl [3];
  logic [5:0] mirror [64];
  logic [5:0] dflt [12] = '{6'h11, 6'h05, 6'h04, 6'h03, 6'h02, 6'h06,
                            6'h11, 6'h0D, 6'h0C, 6'h0B, 6'h0A, 6'h2E};
  logic [5:0] cfg [10] = '{6'h10, 6'h11, 6'h12, 6'h33, 6'h00,
                           6'h01, 6'h07, 6'h08, 6'h09, 6'h2F};
  logic [15:0] seed = 16'h142B;
  logic       exp_bits [$];
  logic [5:0] exp_rd [$];
  int         mismatches = 0;
  int         cmp_count = 0;
  datagram_sequencer datagram_sequencer_inst (.core_clk(core_clk), .rstn(rstn),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .motor_ctl(motor_ctl), .tx_request(tx_request),
    .last_driver_index(last_driver_index), .chain_sclk(chain_sclk),
    .chain_select_n(chain_select_n), .chain_sdo(chain_sdo), .busy(busy));
  chain_model chain_model_inst (.core_clk(core_clk), .chain_sclk(chain_sclk),
    .chain_select_n(chain_select_n), .chain_sdo(chain_sdo),
    .bit_valid(bit_valid), .bit_val(bit_val));
  initial forever #50 core_clk = ~core_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic bsel(input motor_ctl_t m, input logic [4:0] c);
    case (c)
      5'h06: return m.coil_a_polarity;
      5'h07: return m.coil_a_fast_decay;
      5'h0E: return m.coil_b_polarity;
      5'h0F: return m.coil_b_fast_decay;
      5'h10: return 1'b0;
      5'h11: return 1'b1;
      5'h12: return m.direction;
      5'h13: return m.step;
      default: return c[3] ? m.coil_b_current[c[2:0]] : m.coil_a_current[c[2:0]];
    endcase
  endfunction
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [5:0] d);
    @(posedge core_clk);
    mem_addr <= a;
    mem_wdata <= d;
    mem_wr <= 1'b1;
    mirror[a] = d;
    @(posedge core_clk);
    mem_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge core_clk);
    mem_addr <= a;
    mem_rd <= 1'b1;
    exp_rd.push_back(mirror[a]);
    @(posedge core_clk);
    mem_rd <= 1'b0;
  endtask
  task automatic shuffle();
    for (int m = 0; m < 3; m++)
    begin
      seed = lfsr(seed);
      motor_ctl[m] <= motor_ctl_t'({seed, seed[15:14]});
    end
  endtask
  task automatic expect_dg();
    logic [1:0] idx;
    idx = 2'h0;
    for (int w = 0; w < 64; w++)
    begin
      exp_bits.push_back(bsel(motor_ctl[idx], mirror[w][4:0]));
      if (mirror[w][5])
      begin
        if (idx == last_driver_index)
          break;
        idx++;
      end
    end
  endtask
  task automatic request();
    @(posedge core_clk);
    tx_request <= 1'b1;
    expect_dg();
    @(posedge core_clk);
    tx_request <= 1'b0;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 3000 && (exp_bits.size() != 0 || busy !== 1'b0); i++)
      @(posedge core_clk);
    chk({5'h00, exp_bits.size() != 0}, 6'h00);
  endtask
  always @(posedge core_clk)
  begin
    if (bit_valid === 1'b1)
      chk({5'h00, bit_val}, {5'h00, exp_bits.size() ? exp_bits.pop_front() : 1'bx});
    if (rd_seen === 1'b1)
      chk(mem_rdata, exp_rd.size() ? exp_rd.pop_front() : 6'hXX);
    rd_seen <= mem_rd;
  end
  initial
  begin
    for (int m = 0; m < 3; m++)
      motor_ctl[m] = '0;
    for (int i = 0; i < 64; i++)
      mirror[i] = (i < 36) ? dflt[i % 12] : 6'h10;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk({4'h0, busy, chain_select_n}, 6'h01);
    for (int i = 0; i < 64; i++)
      rd(i[5:0]);
    shuffle();
    request();
    repeat (100) @(posedge core_clk);
    wr(6'h3F, 6'h2A);
    rd(6'h3F);
    shuffle();
    request();
    wait_done();
    last_driver_index <= 2'h1;
    for (int i = 0; i < 10; i++)
      wr(i[5:0], cfg[i]);
    shuffle();
    request();
    wait_done();
    chk({5'h00, chain_select_n}, 6'h01);
    tally_and_finish();
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end
endmodule
bind datagram_sequencer seq_props seq_props_inst (.core_clk(core_clk), .rstn(rstn),
  .mem_rd(mem_rd), .mem_rdata(mem_rdata), .tx_request(tx_request),
  .chain_sclk(chain_sclk), .chain_select_n(chain_select_n),
  .chain_sdo(chain_sdo), .busy(busy));
`default_nettype wire
